// *** hw/rm_buf.sv ***
// three payload buffers of 32 bytes, each with its own byte pointer
`timescale 1ns/1ns
`include "rm_regs.svh"
module rm_buf (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rstn,
   // access from the serial engine
   rm_buf_if.mem     bus
);
   import rm_pkg::*;
   rm_byte_t   mem_q [`RM_BUF_COUNT][`RM_BUF_DEPTH];
   logic [4:0] ptr_q [`RM_BUF_COUNT];

   // one storage slice per buffer (see RQ10)
   for (genvar k = 0; k < `RM_BUF_COUNT; k++) begin : g_buf
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            ptr_q[k] <= 5'h00;
            for (int i = 0; i < `RM_BUF_DEPTH; i++) begin
               mem_q[k][i] <= 8'h00;
            end
         end else if (bus.hit && bus.sel == 2'(k)) begin
            if (bus.rewind) begin
               ptr_q[k] <= 5'h00;
            end else if (bus.wr) begin
               mem_q[k][ptr_q[k]] <= bus.wdata;
               ptr_q[k]           <= ptr_q[k] + 5'h01; // wraps at 32
            end else if (bus.rd_adv) begin
               ptr_q[k] <= ptr_q[k] + 5'h01;
            end
         end
      end
   end

   // read data of the selected buffer: entry 0 on rewind, else the entry after its pointer
   always_comb begin
      bus.rdata = 8'h00;
      for (int k = 0; k < `RM_BUF_COUNT; k++) begin
         if (bus.sel == 2'(k)) begin
            // command byte shows entry 0, each data byte of a read loads the entry after the pointer
            bus.rdata = bus.rewind ? mem_q[k][0] : mem_q[k][ptr_q[k] + 5'h01];
         end
      end
   end
endmodule

// *** hw/rm_buf_if.sv ***
// carrier between the serial engine and the payload buffer bank
`timescale 1ns/1ns
interface rm_buf_if;
   logic           hit;
   logic [1:0]     sel;
   logic           rewind;
   logic           wr;
   rm_pkg::rm_byte_t wdata;
   logic           rd_adv;
   rm_pkg::rm_byte_t rdata;
   modport ctl (output hit, sel, rewind, wr, wdata, rd_adv, input rdata);
   modport mem (input hit, sel, rewind, wr, wdata, rd_adv, output rdata);
endinterface

// *** hw/rm_ctrl.sv ***
// serial control, power states and interrupt of the radio module
// Summary of operation
// (RQ1) enable pin low forces full power down
// (RQ2) activate input starts active receive or transmit
// (RQ3) events drive maskable active-low interrupt output
// (RQ4) power bit zero enters power down
// (RQ5) power bit set, activate low: standby one
// (RQ6) power bit set, activate high: standby two; code: only with role bit zero, else active receive
// (RQ7) read command has leading zero bits
// (RQ8) command bit five set means write
// (RQ9) host waits 100 ms after enabling; the bench host starts a transfer 8 clock cycles after enabling
// (RQ10) three payload buffers of 32 bytes
// (RQ11) power bit at config bit one
// (RQ12) role bit one selects receiver role
// (RQ13) mask bit one keeps event off pin
// (RQ14) host frames transfers with select low
`timescale 1ns/1ns
`include "rm_regs.svh"
module rm_ctrl (
   // clock and reset
   input  wire logic            core_clk,
   input  wire logic            rstn,
   // control pins from the host
   input  wire logic            power_enable,
   input  wire logic            activate,
   // serial link pins
   input  wire logic            serial_select_n,
   input  wire logic            serial_clk,
   input  wire logic            serial_mosi,
   output logic                 serial_miso,
   output logic                 serial_miso_oe,
   // interrupt pin
   output logic                 irq_n,
   // events from the radio datapath
   input  wire logic            rx_data_evt,
   input  wire logic            tx_sent_evt,
   input  wire logic            retry_limit_evt,
   // power state toward the radio
   output rm_pkg::rm_pstate_e   power_state,
   output logic                 osc_run,
   output logic                 synth_run,
   output logic                 tx_send
);
   import rm_pkg::*;

   rm_buf_if bif ();
   rm_buf u_buf (.core_clk(core_clk), .rstn(rstn), .bus(bif.ctl));

   logic [4:0] meta_q, sync_q;
   logic       sck_prev_q, sel_prev_q;
   logic       en_s, act_s, sel_n_s, sel_s, sck_s, mosi_s;
   logic       rise, fall;
   logic [2:0] bit_q;
   logic       first_q;
   rm_byte_t   shift_q, cmd_q, tx_q, cfg_q, status_q, rx_byte;
   logic       byte_done, is_wr, is_rd, wr_cfg, wr_status, buf_hit;
   rm_pstate_e state_q, state_d;
   rm_byte_t   rd_val;
   logic       irq_cause;

   // two-stage synchronisers for every pin input
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 5'h04;                                            // select idles high
         sync_q <= 5'h04;
      end else begin
         meta_q <= {power_enable, activate, serial_select_n, serial_clk, serial_mosi};
         sync_q <= meta_q;
      end
   end
   assign {en_s, act_s, sel_n_s, sck_s, mosi_s} = sync_q;
   assign sel_s = !sel_n_s;

   // edge finder on the synchronised serial clock
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sck_prev_q <= 1'b0;
         sel_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_s;
         sel_prev_q <= sel_s && en_s;
      end
   end
   assign rise      = sel_s && en_s && sck_s && !sck_prev_q;
   assign fall      = sel_s && en_s && !sck_s && sck_prev_q;
   assign rx_byte   = {shift_q[6:0], mosi_s};
   assign byte_done = rise && bit_q == 3'h7;

   // command decode: bit five writes, leading zeros read
   assign is_wr     = cmd_q[`RM_BIT_WRITE];                          // see RQ8
   assign is_rd     = cmd_q[7:5] == 3'h0;                            // see RQ7
   assign buf_hit   = cmd_q[4:0] >= `RM_BUF_BASE;
   assign wr_cfg    = byte_done && !first_q && is_wr && cmd_q[4:0] == `RM_CFG_ADDR;
   assign wr_status = byte_done && !first_q && is_wr && cmd_q[4:0] == `RM_STATUS_ADDR;

   // register read selection
   always_comb begin
      rd_val = 8'h00;
      if (first_q ? rx_byte[4:0] == `RM_CFG_ADDR : cmd_q[4:0] == `RM_CFG_ADDR) begin
         rd_val = cfg_q;
      end else if (first_q ? rx_byte[4:0] == `RM_STATUS_ADDR
                           : cmd_q[4:0] == `RM_STATUS_ADDR) begin
         rd_val = status_q;
      end else if (first_q ? rx_byte[4:0] >= `RM_BUF_BASE : buf_hit) begin
         rd_val = bif.rdata;
      end
   end

   // payload buffer access (see RQ10)
   always_comb begin
      bif.sel    = first_q ? 2'(rx_byte[4:0] - `RM_BUF_BASE) : 2'(cmd_q[4:0] - `RM_BUF_BASE);
      bif.hit    = byte_done && (first_q ? rx_byte[4:0] >= `RM_BUF_BASE : buf_hit);
      bif.rewind = first_q;
      bif.wr     = !first_q && is_wr;
      bif.wdata  = rx_byte;
      bif.rd_adv = !first_q && is_rd;
   end

   // serial shifter, bit counter and output data
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bit_q       <= 3'h0;
         first_q     <= 1'b1;
         shift_q     <= 8'h00;
         cmd_q       <= 8'h00;
         tx_q        <= 8'h00;
         serial_miso <= 1'b0;
      end else if (!(sel_s && en_s)) begin                           // see RQ14
         bit_q   <= 3'h0;
         first_q <= 1'b1;
      end else if (!sel_prev_q) begin
         serial_miso <= status_q[7];                                 // status leads each frame
         tx_q        <= {status_q[6:0], 1'b0};
      end else if (rise) begin
         shift_q <= rx_byte;
         bit_q   <= bit_q + 3'h1;
         if (byte_done) begin
            first_q <= 1'b0;
            if (first_q) begin
               cmd_q <= rx_byte;
               tx_q  <= rd_val;
            end else if (is_rd) begin
               tx_q <= rd_val;
            end else begin
               tx_q <= 8'h00;
            end
         end
      end else if (fall) begin
         serial_miso <= tx_q[7];
         tx_q        <= {tx_q[6:0], 1'b0};
      end
   end
   assign serial_miso_oe = sel_s && en_s;

   // configuration register: masks, crc, power bit, role bit
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= `RM_CFG_RESET;
      end else if (!en_s) begin
         cfg_q <= `RM_CFG_RESET;                                     // see RQ1
      end else if (wr_cfg) begin
         cfg_q <= {1'b0, rx_byte[6:0]};                              // see RQ11
      end
   end

   // sticky event flags, a set beats a clear by write-one
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         status_q <= `RM_STATUS_RESET;
      end else if (!en_s) begin
         status_q <= `RM_STATUS_RESET;
      end else begin
         status_q[`RM_FLAG_HI:`RM_FLAG_LO] <=
            (status_q[`RM_FLAG_HI:`RM_FLAG_LO] &
             ~(wr_status ? rx_byte[`RM_FLAG_HI:`RM_FLAG_LO] : 3'h0)) |
            {rx_data_evt, tx_sent_evt, retry_limit_evt};
      end
   end

   // interrupt pin from unmasked flags
   assign irq_cause = |(status_q[`RM_FLAG_HI:`RM_FLAG_LO] & ~cfg_q[`RM_FLAG_HI:`RM_FLAG_LO]);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= !irq_cause;                                        // see RQ3, RQ13
      end
   end

   // power state selection
   always_comb begin
      case (1'b1)
         !en_s:                      state_d = PS_OFF;               // see RQ1
         !cfg_q[`RM_BIT_POWER_ON]:   state_d = PS_DOWN;              // see RQ4
         !act_s:                     state_d = PS_STBY_ONE;          // see RQ5
         cfg_q[`RM_BIT_ROLE]:        state_d = PS_ACT_RX;            // see RQ2, RQ12
         default:                    state_d = PS_STBY_TWO;          // see RQ6
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= PS_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // radio steering outputs
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         osc_run   <= 1'b0;
         synth_run <= 1'b0;
         tx_send   <= 1'b0;
      end else begin
         case (state_d)
            PS_STBY_ONE: begin
               osc_run   <= 1'b1;
               synth_run <= 1'b0;
               tx_send   <= 1'b0;
            end
            PS_STBY_TWO: begin
               osc_run   <= 1'b1;
               synth_run <= 1'b1;                                    // see RQ6
               tx_send   <= 1'b1;
            end
            PS_ACT_RX: begin
               osc_run   <= 1'b1;
               synth_run <= 1'b1;
               tx_send   <= 1'b0;
            end
            default: begin
               osc_run   <= 1'b0;
               synth_run <= 1'b0;
               tx_send   <= 1'b0;
            end
         endcase
      end
   end
   assign power_state = state_q;

   // checks
   a_off_when_off: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ1
      !en_s |=> state_q == PS_OFF && !osc_run ##1 cfg_q == `RM_CFG_RESET)
      else $error("not off while enable low");
   a_down_on_clear: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ4
      en_s && !cfg_q[`RM_BIT_POWER_ON] |=> state_q == PS_DOWN && !osc_run)
      else $error("power bit clear but not down");
   a_standby_one: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ5
      en_s && cfg_q[`RM_BIT_POWER_ON] && !act_s |=>
         state_q == PS_STBY_ONE && osc_run && !synth_run)
      else $error("standby one not entered");
   a_standby_two: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ6
      en_s && cfg_q[1:0] == 2'h2 && act_s |=> state_q == PS_STBY_TWO && synth_run && tx_send)
      else $error("standby two not entered");
   a_active_rx: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ2
      en_s && cfg_q[1:0] == 2'h3 && act_s |=> state_q == PS_ACT_RX && !tx_send)
      else $error("receive role not active");
   a_irq_level: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ3
      irq_cause |=> !irq_n ##0 ($past(irq_cause) == !irq_n))
      else $error("interrupt pin does not follow flags");
   a_irq_masked: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ13
      (status_q[6:4] & ~cfg_q[6:4]) == 3'h0 |=> irq_n)
      else $error("masked event reached the pin");
   a_cfg_write: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ8
      wr_cfg && en_s |=> cfg_q[6:0] == $past(rx_byte[6:0]))
      else $error("config write lost");
   a_read_keeps: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ7
      byte_done && !first_q && is_rd && en_s |=> cfg_q == $past(cfg_q))
      else $error("read command changed config");
   a_set_wins: assert property (@(posedge core_clk) disable iff (!rstn) // see RQ3
      en_s && rx_data_evt |=> status_q[6])
      else $error("event lost against clear");
endmodule

// *** hw/rm_pkg.sv ***
// types shared by the radio control block
package rm_pkg;
   typedef enum logic [4:0] {
      PS_OFF      = 5'h01,
      PS_DOWN     = 5'h02,
      PS_STBY_ONE = 5'h04,
      PS_STBY_TWO = 5'h08,
      PS_ACT_RX   = 5'h10
   } rm_pstate_e;
   typedef logic [7:0] rm_byte_t;
endpackage

// *** hw/rm_regs.svh ***
// register offsets, field positions and reset values of the radio control block
`ifndef RM_REGS_SVH
`define RM_REGS_SVH
`define RM_CFG_ADDR      5'h00
`define RM_STATUS_ADDR   5'h07
`define RM_BUF_BASE      5'h1d
`define RM_BUF_COUNT     3
`define RM_BUF_DEPTH     32
`define RM_CFG_RESET     8'h00
`define RM_STATUS_RESET  8'h00
`define RM_BIT_ROLE      0
`define RM_BIT_POWER_ON  1
`define RM_BIT_WRITE     5
`define RM_FLAG_LO       4
`define RM_FLAG_HI       6
`endif

// *** testbench/rm_ctrl_tb_top.sv ***
// self-checking bench for the radio control block
`timescale 1ns/1ns
module rm_ctrl_tb_top;
   import rm_pkg::*;
   logic       core_clk, rstn, power_enable, activate;
   logic       serial_select_n, serial_clk, serial_mosi, serial_miso, serial_miso_oe;
   logic       irq_n, osc_run, synth_run, tx_send;
   logic [2:0] evt;
   rm_pstate_e power_state;
   rm_byte_t   st, rd;
   int         fails, cmp_count, cyc;

   // device and host
   rm_ctrl dut (.core_clk(core_clk), .rstn(rstn), .power_enable(power_enable),
      .activate(activate), .serial_select_n(serial_select_n), .serial_clk(serial_clk),
      .serial_mosi(serial_mosi), .serial_miso(serial_miso),
      .serial_miso_oe(serial_miso_oe), .irq_n(irq_n), .rx_data_evt(evt[2]),
      .tx_sent_evt(evt[1]), .retry_limit_evt(evt[0]), .power_state(power_state),
      .osc_run(osc_run), .synth_run(synth_run), .tx_send(tx_send));
   rm_host host (.core_clk(core_clk), .serial_select_n(serial_select_n),
      .serial_clk(serial_clk), .serial_mosi(serial_mosi), .serial_miso(serial_miso));

   // 25 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // power state and run outputs after settling
   task automatic pchk(input rm_pstate_e e, input logic [2:0] runs);
      repeat (8) @(negedge core_clk);
      chk("power_state", {3'h0, e}, {3'h0, power_state});
      chk("run_outputs", {5'h00, runs}, {5'h00, osc_run, synth_run, tx_send});
   endtask

   // standby levels, active, refused command, power bit off
   task automatic t_power();
      host.xfer(8'h20, 8'h02, st, rd);
      pchk(PS_STBY_ONE, 3'h4);
      host.xfer(8'h00, 8'h00, st, rd);
      chk("cfg_read", 8'h02, rd);
      activate = 1'b1;
      pchk(PS_STBY_TWO, 3'h7);
      host.xfer(8'h20, 8'h03, st, rd);
      pchk(PS_ACT_RX, 3'h6);
      host.xfer(8'h80, 8'h00, st, rd);
      pchk(PS_ACT_RX, 3'h6);
      activate = 1'b0;
      pchk(PS_STBY_ONE, 3'h4);
      host.xfer(8'h20, 8'h00, st, rd);
      pchk(PS_DOWN, 3'h0);
   endtask

   // each event raises, is masked, is cleared
   task automatic t_irq();
      for (int i = 0; i < 3; i++) begin
         evt[i] = 1'b1;
         @(negedge core_clk);
         evt[i] = 1'b0;
         repeat (4) @(negedge core_clk);
         chk("irq_n_raised", 8'h00, {7'h00, irq_n});
         host.xfer(8'h07, 8'h00, st, rd);
         chk("status_cmd", 8'h10 << i, st);
         chk("status_read", 8'h10 << i, rd);
         host.xfer(8'h20, 8'h10 << i, st, rd);
         chk("irq_n_masked", 8'h01, {7'h00, irq_n});
         host.xfer(8'h27, 8'h10 << i, st, rd);
         host.xfer(8'h20, 8'h00, st, rd);
         host.xfer(8'h07, 8'h00, st, rd);
         chk("status_clear", 8'h00, rd);
         chk("irq_n_idle", 8'h01, {7'h00, irq_n});
      end
   endtask

   // payload buffers keep their own bytes
   task automatic t_buf();
      host.xfer(8'h3d, 8'ha5, st, rd);
      host.xfer(8'h3f, 8'h5a, st, rd);
      host.xfer(8'h1d, 8'h00, st, rd);
      chk("buf0", 8'ha5, rd);
      host.xfer(8'h1f, 8'h00, st, rd);
      chk("buf2", 8'h5a, rd);
   endtask

   // enable pin low forces full power down and clears config
   task automatic t_enable();
      host.xfer(8'h20, 8'h02, st, rd);
      power_enable = 1'b0;
      pchk(PS_OFF, 3'h0);
      // a frame while disabled: output stays off and the write is dropped
      fork
         host.xfer(8'h20, 8'h02, st, rd);
         begin
            repeat (20) @(negedge core_clk);
            chk("oe_disabled", 8'h00, {7'h00, serial_miso_oe});
         end
      join
      power_enable = 1'b1;
      pchk(PS_DOWN, 3'h0);
      host.xfer(8'h00, 8'h00, st, rd);
      chk("cfg_cleared", 8'h00, rd);
   endtask

   // main sequence
   initial begin
      rstn         = 1'b0;
      power_enable = 1'b1;
      activate     = 1'b0;
      evt          = 3'h0;
      repeat (12) @(negedge core_clk);
      chk("rst_state", {3'h0, PS_OFF}, {3'h0, power_state});
      chk("rst_irq_n", 8'h01, {7'h00, irq_n});
      rstn = 1'b1;
      pchk(PS_DOWN, 3'h0);
      t_power();
      t_irq();
      t_buf();
      t_enable();
      stop_test();
   end
endmodule

// *** testbench/rm_host.sv ***
// host-side serial master model for the radio control block
`timescale 1ns/1ns
module rm_host (
   // clock
   input  wire logic core_clk,
   // serial link
   output logic      serial_select_n,
   output logic      serial_clk,
   output logic      serial_mosi,
   input  wire logic serial_miso
);
   import rm_pkg::*;
   // idle: deselected, clock parked low between frames
   initial begin
      serial_select_n = 1'b1;
      serial_clk      = 1'b0;
      serial_mosi     = 1'b0;
   end
   // one byte msb first; clock low 5 cycles, high 3 (320 ns)
   task automatic xbyte(input rm_byte_t tx, output rm_byte_t rx);
      for (int i = 7; i >= 0; i--) begin
         serial_mosi = tx[i];
         repeat (5) @(negedge core_clk);
         rx[i] = serial_miso; // sampled late in the low phase, after miso settled
         serial_clk = 1'b1;
         repeat (3) @(negedge core_clk);
         serial_clk = 1'b0;
      end
   endtask
   // framed command plus one data byte
   task automatic xfer(input rm_byte_t cmd, input rm_byte_t dat,
                       output rm_byte_t st, output rm_byte_t rd);
      serial_select_n = 1'b0;
      xbyte(cmd, st);
      xbyte(dat, rd);
      repeat (4) @(negedge core_clk);
      serial_select_n = 1'b1;
      serial_mosi = ~serial_mosi; // released line does not hold the last bit
      repeat (4) @(negedge core_clk);
   endtask
endmodule
